// File: rtl/pmbus_status_pkg.sv
// Constants shared by the status and timing configuration block.
// Notes on behaviour
// R1 - Raw status bits follow their condition live.
// R2 - Latched flags stay set until cleared.
// R3 - Word read 79h; byte read 78h low byte.
// R4 - Unsupported status positions always read zero.
// R5 - Low bit 6 high when not delivering power.
// R6 - Low bits 5..1 latch OV, OC, UVLO, OT, COMMS_MEMORY_LOGIC_FLAG.
// R7 - High bits 7..5 latch voltage, current, input summaries.
// R8 - High bit 3 mirrors power-good pin level.
// R9 - Flags clear on clear command, re-enable, power-up.
// R10 - Present fault sets flag again, alert re-asserts.
// R11 - Alert output signals fault conditions.
// R12 - Host should read status on alert, not poll.
// R13 - D0h holds six-bit user value, default zero.
// R14 - Unused upper configuration bits ignored on write.
// R15 - D1h bits 5:3 pick power-good delay.
// R16 - D1h bits 2:0 pick power-on delay.
// R17 - D2h bits 3:2 pick soft-start time.
// R18 - D2h bit 1 picks hiccup or latch-off.
// R19 - D2h bit 0 picks conduction; soft-start stays discontinuous.
// R20 - Command 03h clears status and releases alert.
// R21 - Clear command never restarts latched-off converter.
// R22 - Enable: power-on delay, soft-start, then power-good delay.
// R23 - Ignored configuration bits read back as zero.
package pmbus_status_pkg;

    // Command codes.
    localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CODE_STATUS_LOW = 8'h78;
    localparam logic [7:0] CODE_STATUS_WORD = 8'h79;
    localparam logic [7:0] CODE_USER_SCRATCH = 8'hd0;
    localparam logic [7:0] CODE_DELAY_SELECT = 8'hd1;
    localparam logic [7:0] CODE_MODE_RAMP = 8'hd2;

    // Writable masks of the configuration bytes.
    localparam logic [7:0] USER_SCRATCH_MASK = 8'h3f;
    localparam logic [7:0] DELAY_SELECT_MASK = 8'h3f;
    localparam logic [7:0] MODE_RAMP_MASK = 8'h0f;

    // Reset values of the configuration bytes.
    localparam logic [7:0] USER_SCRATCH_RESET = 8'h00;
    localparam logic [7:0] DELAY_SELECT_RESET = 8'h12;
    localparam logic [7:0] MODE_RAMP_RESET = 8'h00;

    // Field positions.
    localparam int PGD_LSB = 3;
    localparam int POD_LSB = 0;
    localparam int SST_LSB = 2;
    localparam int UV_RESP_BIT = 1;
    localparam int COND_BIT = 0;
    localparam int ST_OFF_BIT = 6;
    localparam int ST_OV_BIT = 5;
    localparam int ST_OC_BIT = 4;
    localparam int ST_UV_BIT = 3;
    localparam int ST_OT_BIT = 2;
    localparam int ST_CML_BIT = 1;
    localparam int ST_OUTPUT_VOLTAGE_SUMMARY_FLAG_BIT = 15;
    localparam int ST_OUTPUT_CURRENT_SUMMARY_FLAG_BIT = 14;
    localparam int ST_INPUT_BIT = 13;
    localparam int ST_POWER_GOOD_PIN_LEVEL_BIT = 11;

    // Timing base figures in nanoseconds and the clock period.
    localparam int CLK_PERIOD_NS = 20;
    localparam int PGD_UNIT_NS = 256000;
    localparam int PGD_LONG_NS = 131072000;
    localparam int POD_OFFSET_NS = 100000;
    localparam int SS_UNIT_NS = 1000000;
    localparam int HICCUP_BASE_NS = 8960000;
    localparam int HICCUP_SS_MULT = 7;
    localparam int PGD_LONG_CODE = 7;

    // Cycle counts derived from the figures above.
    localparam int PGD_UNIT_CYC = PGD_UNIT_NS / CLK_PERIOD_NS;
    localparam int PGD_LONG_CYC = PGD_LONG_NS / CLK_PERIOD_NS;
    localparam int POD_OFFSET_CYC = POD_OFFSET_NS / CLK_PERIOD_NS;
    localparam int SS_UNIT_CYC = SS_UNIT_NS / CLK_PERIOD_NS;
    localparam int HICCUP_BASE_CYC = HICCUP_BASE_NS / CLK_PERIOD_NS;

    // Power sequence states, one-hot.
    typedef enum logic [6:0] {
        SEQ_OFF = 7'h01,
        SEQ_POD = 7'h02,
        SEQ_RAMP = 7'h04,
        SEQ_PGD = 7'h08,
        SEQ_ON = 7'h10,
        SEQ_HICCUP = 7'h20,
        SEQ_LATCHED = 7'h40
    } seq_state_e;

endpackage

// File: rtl/phase_timer.sv
// Down-counter that times one phase of the power sequence.
`timescale 1ns/1ps
`default_nettype none
module phase_timer #(
    parameter int WIDTH = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic expired
);

    logic [WIDTH-1:0] count;
    logic running;

    // A load restarts the count; the phase ends when it reaches one.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            count <= '0;
            running <= 1'b0;
        end
        else if (load)
        begin
            count <= load_value;
            running <= 1'b1;
        end
        else if (running)
        begin
            count <= count - WIDTH'(1);
            running <= (count > WIDTH'(1));
        end
    end

    // Pulses in the last cycle of the loaded span.
    // The load is left out here, since the caller derives its load from this pulse.
    assign expired = running && (count == WIDTH'(1));

endmodule
`default_nettype wire

// File: rtl/pmbus_status_and_timing_config.sv
// Status word, fault flags, alert and timing configuration of the converter.
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_and_timing_config #(
    parameter int PGD_UNIT_CYC = pmbus_status_pkg::PGD_UNIT_CYC,
    parameter int PGD_LONG_CYC = pmbus_status_pkg::PGD_LONG_CYC,
    parameter int POD_OFFSET_CYC = pmbus_status_pkg::POD_OFFSET_CYC,
    parameter int SS_UNIT_CYC = pmbus_status_pkg::SS_UNIT_CYC,
    parameter int HICCUP_BASE_CYC = pmbus_status_pkg::HICCUP_BASE_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_code,
    input wire logic [7:0] req_wdata,
    input wire logic converter_enable,
    input wire logic ov_cond,
    input wire logic oc_cond,
    input wire logic vin_uvlo_cond,
    input wire logic ot_cond,
    input wire logic cml_cond,
    input wire logic output_voltage_summary_flag_warn_cond,
    input wire logic output_current_summary_flag_warn_cond,
    input wire logic vin_warn_cond,
    input wire logic output_uv_cond,
    input wire logic power_good_pin_level,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic alert_n,
    output logic power_good,
    output logic delivering,
    output logic soft_start_active,
    output logic forced_continuous_conduction
);

    localparam int NSYNC = 11;

    // Two-stage synchronisers for every pin input.
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync_meta;
    logic [NSYNC-1:0] sync_out;

    assign pin_raw = {power_good_pin_level, output_uv_cond, vin_warn_cond, output_current_summary_flag_warn_cond,
        output_voltage_summary_flag_warn_cond, cml_cond, ot_cond, vin_uvlo_cond, oc_cond, ov_cond, converter_enable};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++)
        begin : g_sync
            always_ff @(posedge core_clk)
            begin
                if (sys_rst)
                begin
                    sync_meta[gi] <= 1'b0;
                    sync_out[gi] <= 1'b0;
                end
                else
                begin
                    sync_meta[gi] <= pin_raw[gi];
                    sync_out[gi] <= sync_meta[gi];
                end
            end
        end
    endgenerate

    // Named views of the synchronised inputs.
    wire en_s = sync_out[0];
    wire ov_s = sync_out[1];
    wire oc_s = sync_out[2];
    wire uvlo_s = sync_out[3];
    wire ot_s = sync_out[4];
    wire cml_s = sync_out[5];
    wire vwarn_s = sync_out[6];
    wire iwarn_s = sync_out[7];
    wire inwarn_s = sync_out[8];
    wire out_uv_s = sync_out[9];
    wire pg_pin_s = sync_out[10];

    // Configuration bytes, held at their defaults after power-up.
    logic [7:0] user_scratch_byte;
    logic [7:0] delay_select;
    logic [7:0] mode_and_ramp_config;

    // Field views of the configuration bytes.
    wire [5:0] user_scratch_value = user_scratch_byte[5:0];
    wire [2:0] power_good_delay_select = delay_select[pmbus_status_pkg::PGD_LSB +: 3];
    wire [2:0] power_on_delay_select = delay_select[pmbus_status_pkg::POD_LSB +: 3];
    wire [1:0] soft_start_time_select = mode_and_ramp_config[pmbus_status_pkg::SST_LSB +: 2];
    wire undervoltage_response_select = mode_and_ramp_config[pmbus_status_pkg::UV_RESP_BIT];
    wire conduction_select = mode_and_ramp_config[pmbus_status_pkg::COND_BIT];

    // Command decode.
    wire do_write = req_valid && req_write;
    wire do_read = req_valid && !req_write;
    wire clear_cmd = do_write && (req_code == pmbus_status_pkg::CODE_CLEAR_FAULTS); // [R20]
    wire wr_scratch = do_write && (req_code == pmbus_status_pkg::CODE_USER_SCRATCH);
    wire wr_delay = do_write && (req_code == pmbus_status_pkg::CODE_DELAY_SELECT);
    wire wr_mode = do_write && (req_code == pmbus_status_pkg::CODE_MODE_RAMP);

    // Writes keep only the supported bits; the rest store and read as zero.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            user_scratch_byte <= pmbus_status_pkg::USER_SCRATCH_RESET; // [R13]
            delay_select <= pmbus_status_pkg::DELAY_SELECT_RESET;
            mode_and_ramp_config <= pmbus_status_pkg::MODE_RAMP_RESET;
        end
        else
        begin
            if (wr_scratch)
                user_scratch_byte <= req_wdata & pmbus_status_pkg::USER_SCRATCH_MASK; // [R14] [R23]
            if (wr_delay)
                delay_select <= req_wdata & pmbus_status_pkg::DELAY_SELECT_MASK; // [R14] [R23]
            if (wr_mode)
                mode_and_ramp_config <= req_wdata & pmbus_status_pkg::MODE_RAMP_MASK; // [R14] [R23]
        end
    end

    // Enable edge: an off-then-on command clears the latched flags.
    logic en_prev;
    wire en_rise = en_s && !en_prev;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            en_prev <= 1'b0;
        else
            en_prev <= en_s;
    end

    // Latched fault flags: a present condition wins over the clear.
    localparam int NFLAG = 8;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] flag_cond;
    logic [NFLAG-1:0] next_flags;
    wire flag_clear = clear_cmd || en_rise; // [R9]

    assign flag_cond = {inwarn_s | uvlo_s, iwarn_s | oc_s, vwarn_s | ov_s | out_uv_s, // [R7]
        cml_s, ot_s, uvlo_s, oc_s, ov_s}; // [R6]
    assign next_flags = (flags & {NFLAG{!flag_clear}}) | flag_cond; // [R2] [R10]

    // Flags clear on reset, which stands for power-up.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            flags <= '0; // [R9]
            alert_n <= 1'b1;
        end
        else
        begin
            flags <= next_flags;
            alert_n <= !(|next_flags); // [R11] [R10] [R20]
        end
    end

    // Phase lengths picked from the configuration fields.
    logic [31:0] ss_cycles;
    logic [31:0] pod_cycles;
    logic [31:0] pgd_cycles;
    logic [31:0] hiccup_cycles;

    assign ss_cycles = 32'(SS_UNIT_CYC) << soft_start_time_select; // [R17]
    assign pod_cycles = 32'(POD_OFFSET_CYC) + (32'(PGD_UNIT_CYC) << power_on_delay_select); // [R16]
    assign pgd_cycles = (power_good_delay_select == 3'(pmbus_status_pkg::PGD_LONG_CODE)) ?
        32'(PGD_LONG_CYC) : (32'(PGD_UNIT_CYC) << power_good_delay_select); // [R15]
    assign hiccup_cycles = 32'(HICCUP_BASE_CYC) +
        32'(pmbus_status_pkg::HICCUP_SS_MULT) * ss_cycles; // [R18]

    // Power sequence state machine.
    pmbus_status_pkg::seq_state_e state;
    pmbus_status_pkg::seq_state_e next_state;
    logic timer_load;
    logic [31:0] timer_value;
    logic timer_done;

    phase_timer #(
        .WIDTH(32)
    ) u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(timer_load),
        .load_value(timer_value),
        .expired(timer_done)
    );

    wire running_phase = (state == pmbus_status_pkg::SEQ_RAMP) ||
        (state == pmbus_status_pkg::SEQ_PGD) || (state == pmbus_status_pkg::SEQ_ON);

    // Next state and the timer load that starts each phase.
    always_comb
    begin
        next_state = state;
        timer_load = 1'b0;
        timer_value = 32'h0;
        unique case (state)
            pmbus_status_pkg::SEQ_OFF:
            begin
                if (en_s)
                begin
                    next_state = pmbus_status_pkg::SEQ_POD; // [R22]
                    timer_load = 1'b1;
                    timer_value = pod_cycles;
                end
            end
            pmbus_status_pkg::SEQ_POD, pmbus_status_pkg::SEQ_HICCUP:
            begin
                if (timer_done)
                begin
                    next_state = pmbus_status_pkg::SEQ_RAMP; // [R22]
                    timer_load = 1'b1;
                    timer_value = ss_cycles;
                end
            end
            pmbus_status_pkg::SEQ_RAMP:
            begin
                if (timer_done)
                begin
                    next_state = pmbus_status_pkg::SEQ_PGD; // [R22]
                    timer_load = 1'b1;
                    timer_value = pgd_cycles;
                end
            end
            pmbus_status_pkg::SEQ_PGD:
            begin
                if (timer_done)
                    next_state = pmbus_status_pkg::SEQ_ON; // [R22]
            end
            pmbus_status_pkg::SEQ_ON:
            begin
                next_state = pmbus_status_pkg::SEQ_ON;
            end
            pmbus_status_pkg::SEQ_LATCHED:
            begin
                next_state = pmbus_status_pkg::SEQ_LATCHED; // [R21]
            end
        endcase
        if (running_phase && out_uv_s)
        begin
            if (undervoltage_response_select)
            begin
                next_state = pmbus_status_pkg::SEQ_LATCHED; // [R18]
                timer_load = 1'b0;
            end
            else
            begin
                next_state = pmbus_status_pkg::SEQ_HICCUP; // [R18]
                timer_load = 1'b1;
                timer_value = hiccup_cycles;
            end
        end
        if (!en_s)
        begin
            next_state = pmbus_status_pkg::SEQ_OFF;
            timer_load = 1'b0;
        end
    end

    // Converter outputs decoded from the next state.
    wire next_delivering = (next_state == pmbus_status_pkg::SEQ_RAMP) ||
        (next_state == pmbus_status_pkg::SEQ_PGD) || (next_state == pmbus_status_pkg::SEQ_ON);
    wire next_ramp = next_state == pmbus_status_pkg::SEQ_RAMP;
    wire next_pg = next_state == pmbus_status_pkg::SEQ_ON;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state <= pmbus_status_pkg::SEQ_OFF;
            delivering <= 1'b0;
            soft_start_active <= 1'b0;
            power_good <= 1'b0;
            forced_continuous_conduction <= 1'b0;
        end
        else
        begin
            state <= next_state;
            delivering <= next_delivering;
            soft_start_active <= next_ramp;
            power_good <= next_pg; // [R22]
            forced_continuous_conduction <= next_delivering && !next_ramp &&
                conduction_select; // [R19]
        end
    end

    // Status word: raw bits live, latched flags, unsupported bits zero.
    logic [15:0] status_word;

    always_comb
    begin
        status_word = 16'h0000; // [R4]
        status_word[pmbus_status_pkg::ST_OFF_BIT] = !delivering; // [R1] [R5]
        status_word[pmbus_status_pkg::ST_OV_BIT] = flags[0]; // [R6]
        status_word[pmbus_status_pkg::ST_OC_BIT] = flags[1];
        status_word[pmbus_status_pkg::ST_UV_BIT] = flags[2];
        status_word[pmbus_status_pkg::ST_OT_BIT] = flags[3];
        status_word[pmbus_status_pkg::ST_CML_BIT] = flags[4];
        status_word[pmbus_status_pkg::ST_OUTPUT_VOLTAGE_SUMMARY_FLAG_BIT] = flags[5]; // [R7]
        status_word[pmbus_status_pkg::ST_OUTPUT_CURRENT_SUMMARY_FLAG_BIT] = flags[6];
        status_word[pmbus_status_pkg::ST_INPUT_BIT] = flags[7];
        status_word[pmbus_status_pkg::ST_POWER_GOOD_PIN_LEVEL_BIT] = pg_pin_s; // [R1] [R8]
    end

    // Read data selection; an unknown code reads as zero.
    logic [15:0] read_mux;

    always_comb
    begin
        unique case (req_code)
            pmbus_status_pkg::CODE_STATUS_WORD: read_mux = status_word; // [R3]
            pmbus_status_pkg::CODE_STATUS_LOW: read_mux = {8'h00, status_word[7:0]}; // [R3]
            pmbus_status_pkg::CODE_USER_SCRATCH: read_mux = {10'h000, user_scratch_value};
            pmbus_status_pkg::CODE_DELAY_SELECT: read_mux = {8'h00, delay_select};
            pmbus_status_pkg::CODE_MODE_RAMP: read_mux = {8'h00, mode_and_ramp_config};
            default: read_mux = 16'h0000;
        endcase
    end

    // Read answer one cycle after the request.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
        end
        else
        begin
            rsp_valid <= do_read;
            rsp_data <= do_read ? read_mux : 16'h0000;
        end
    end

endmodule
`default_nettype wire

// File: tb/pmbus_status_monitor.sv
// Concurrent checks on the ports of the status and timing block.
`timescale 1ns/1ps
`default_nettype none
module pmbus_status_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_code,
    input wire logic converter_enable,
    input wire logic ov_cond,
    input wire logic oc_cond,
    input wire logic vin_uvlo_cond,
    input wire logic ot_cond,
    input wire logic cml_cond,
    input wire logic output_voltage_summary_flag_warn_cond,
    input wire logic output_current_summary_flag_warn_cond,
    input wire logic vin_warn_cond,
    input wire logic output_uv_cond,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    input wire logic alert_n,
    input wire logic power_good,
    input wire logic delivering,
    input wire logic soft_start_active,
    input wire logic forced_continuous_conduction
);
    logic [2:0] quiet;
    wire logic any_cond;
    wire logic rd;
    wire logic clr;

    // Decodes of the command port and of the fault inputs.
    assign any_cond = ov_cond | oc_cond | vin_uvlo_cond | ot_cond | cml_cond | output_voltage_summary_flag_warn_cond
        | output_current_summary_flag_warn_cond | vin_warn_cond | output_uv_cond;
    assign rd = req_valid && !req_write;
    assign clr = req_valid && req_write && req_code == 8'h03;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Counts quiet cycles so a clear is judged only once the synchronisers are flushed.
    always_ff @(posedge core_clk)
        if (sys_rst || any_cond)
            quiet <= 3'h0;
        else if (quiet != 3'h7)
            quiet <= quiet + 3'h1;

    a_read_answer: assert property (rd |=> rsp_valid)
        else $error("read not answered in one cycle");
    a_no_stray_answer: assert property (!rd |=> !rsp_valid)
        else $error("answer without a read");
    a_word_reserved: assert property (rsp_valid && $past(req_code) == 8'h79 |->
        (rsp_data & 16'h1781) == 16'h0000) else $error("reserved status bit set");
    a_byte_low_only: assert property (rsp_valid && $past(req_code) == 8'h78 |->
        rsp_data[15:8] == 8'h00 && !rsp_data[7] && !rsp_data[0]) else $error("bad low byte");
    a_fault_alert: assert property ($rose(ov_cond) |-> ##[2:3] !alert_n)
        else $error("alert not raised by fault");
    a_clear_release: assert property (clr && quiet >= 3'h4 |=> alert_n)
        else $error("alert not released by clear");
    a_ramp_discont: assert property (soft_start_active |-> !forced_continuous_conduction)
        else $error("forced conduction during ramp");
    a_power_good_pin_level_gap: assert property ($fell(soft_start_active) |-> !power_good [*2])
        else $error("power good without delay");
    a_power_good_pin_level_delivers: assert property (power_good |-> delivering && !soft_start_active)
        else $error("power good while not on");
    a_enable_off: assert property (!converter_enable [*5] |-> !delivering)
        else $error("still delivering after disable");

    c_clear: cover property (clr);
    c_power_good_pin_level: cover property ($rose(power_good));
    c_ramp: cover property ($rose(soft_start_active));
endmodule
`default_nettype wire

// File: tb/pmbus_host_model.sv
// Host model that issues reads and writes on the command port.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
    input wire logic core_clk,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_data,
    output logic req_valid,
    output logic req_write,
    output logic [7:0] req_code,
    output logic [7:0] req_wdata
);
    // The port is idle at time zero.
    initial
    begin
        req_valid = 1'b0;
        req_write = 1'b0;
        req_code = 8'h00;
        req_wdata = 8'h00;
    end

    // One request for one cycle; released code and data lines show the inverse of their last value.
    task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
        output logic [16:0] r);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_code <= c;
        req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        req_code <= ~c;
        req_wdata <= ~d;
        #1;
        r = {rsp_valid, rsp_data};
    endtask
endmodule
`default_nettype wire

// File: tb/pmbus_status_and_timing_config_test.sv
// Self-checking bench for the status and timing configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module pmbus_status_and_timing_config_test;
    logic core_clk, sys_rst, converter_enable, pg_pin, req_valid, req_write, rsp_valid;
    logic alert_n, power_good, delivering, soft_start_active, fcc;
    logic [8:0] cond;
    logic [7:0] req_code, req_wdata;
    logic [15:0] rsp_data;
    int bad_count, checks, n;
    localparam logic [15:0] FLAG_EXP [9] = '{16'h8020, 16'h4010, 16'h2008, 16'h0004,
        16'h0002, 16'h8000, 16'h4000, 16'h2000, 16'h8000};

    pmbus_status_and_timing_config #(.PGD_UNIT_CYC(4), .PGD_LONG_CYC(64), .POD_OFFSET_CYC(2),
        .SS_UNIT_CYC(8), .HICCUP_BASE_CYC(16)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
        .req_wdata(req_wdata), .converter_enable(converter_enable), .ov_cond(cond[0]),
        .oc_cond(cond[1]), .vin_uvlo_cond(cond[2]), .ot_cond(cond[3]), .cml_cond(cond[4]),
        .output_voltage_summary_flag_warn_cond(cond[5]), .output_current_summary_flag_warn_cond(cond[6]), .vin_warn_cond(cond[7]),
        .output_uv_cond(cond[8]), .power_good_pin_level(pg_pin), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .alert_n(alert_n), .power_good(power_good),
        .delivering(delivering), .soft_start_active(soft_start_active),
        .forced_continuous_conduction(fcc));
    pmbus_host_model u_host (.core_clk(core_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
        .req_wdata(req_wdata));

    // Free-running 50 MHz clock.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic stop_test;
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // A read must be answered next cycle with the expected value.
    task automatic read(input logic [7:0] c, input logic [15:0] e);
        logic [16:0] r;
        u_host.xfer(1'b0, c, 8'h00, r);
        `CHK(r, {1'b1, e})
    endtask

    task automatic write(input logic [7:0] c, input logic [7:0] d);
        logic [16:0] r;
        u_host.xfer(1'b1, c, d, r);
    endtask

    task automatic t_defaults;
        read(8'hd0, 16'h0000);
        read(8'hd1, 16'h0012);
        read(8'hd2, 16'h0000);
        read(8'h79, 16'h0040);
        read(8'h78, 16'h0040);
        read(8'h55, 16'h0000);
    endtask

    task automatic t_config;
        write(8'hd0, 8'hff);
        read(8'hd0, 16'h003f);
        write(8'hd1, 8'hc9);
        read(8'hd1, 16'h0009);
        write(8'hd2, 8'hff);
        read(8'hd2, 16'h000f);
        write(8'h79, 8'hff);
        read(8'h79, 16'h0040);
    endtask

    // Each fault input in turn: latch, alert, survive removal, clear.
    task automatic t_flags;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge core_clk);
            cond <= 9'h001 << i;
            idle(6);
            `CHK(alert_n, 1'b0)
            @(posedge core_clk);
            cond <= 9'h000;
            idle(6);
            read(8'h79, FLAG_EXP[i] | 16'h0040);
            read(8'h78, {8'h00, FLAG_EXP[i][7:0] | 8'h40});
            write(8'h03, 8'h00);
            idle(1);
            `CHK(alert_n, 1'b1)
            read(8'h79, 16'h0040);
        end
    endtask

    task automatic t_reassert;
        @(posedge core_clk);
        cond <= 9'h002;
        idle(6);
        write(8'h03, 8'h00);
        idle(1);
        `CHK(alert_n, 1'b0)
        read(8'h79, 16'h4050);
        @(posedge core_clk);
        cond <= 9'h000;
        idle(6);
        write(8'h03, 8'h00);
        idle(1);
        `CHK(alert_n, 1'b1)
    endtask

    task automatic t_raw;
        @(posedge core_clk);
        pg_pin <= 1'b1;
        idle(4);
        read(8'h79, 16'h0840);
        @(posedge core_clk);
        pg_pin <= 1'b0;
        idle(4);
        read(8'h79, 16'h0040);
        `CHK(alert_n, 1'b1)
    endtask

    // Power sequence with short delays, hiccup, latch-off and restart.
    task automatic t_sequence;
        write(8'hd1, 8'h00);
        write(8'hd2, 8'h05);
        @(posedge core_clk);
        converter_enable <= 1'b1;
        for (n = 0; n < 100 && !soft_start_active; n++) idle(1);
        `CHK(n >= 6 && n <= 12, 1'b1)
        `CHK(fcc, 1'b0)
        for (n = 0; n < 100 && soft_start_active; n++) idle(1);
        `CHK(n >= 14 && n <= 18, 1'b1)
        for (n = 0; n < 100 && !power_good; n++) idle(1);
        `CHK(n >= 2 && n <= 7, 1'b1)
        `CHK(fcc, 1'b1)
        read(8'h79, 16'h0000);
        @(posedge core_clk);
        cond <= 9'h100;
        repeat (4) @(posedge core_clk);
        cond <= 9'h000;
        #1;
        for (n = 0; n < 10 && delivering; n++) idle(1);
        `CHK(delivering, 1'b0)
        for (n = 0; n < 300 && !soft_start_active; n++) idle(1);
        `CHK(n >= 124 && n <= 134, 1'b1)
        `CHK(alert_n, 1'b0)
        read(8'h79, 16'h8000);
        write(8'hd2, 8'h07);
        @(posedge core_clk);
        cond <= 9'h100;
        repeat (4) @(posedge core_clk);
        cond <= 9'h000;
        idle(4);
        `CHK(delivering, 1'b0)
        write(8'h03, 8'h00);
        idle(200);
        `CHK(delivering, 1'b0)
        write(8'hd1, 8'h38);
        @(posedge core_clk);
        cond <= 9'h008;
        repeat (4) @(posedge core_clk);
        cond <= 9'h000;
        converter_enable <= 1'b0;
        repeat (6) @(posedge core_clk);
        converter_enable <= 1'b1;
        idle(5);
        `CHK(alert_n, 1'b1)
        for (n = 0; n < 30 && !soft_start_active; n++) idle(1);
        `CHK(soft_start_active, 1'b1)
        for (n = 0; n < 30 && soft_start_active; n++) idle(1);
        for (n = 0; n < 100 && !power_good; n++) idle(1);
        `CHK(n >= 62 && n <= 66, 1'b1)
    endtask

    // Main sequence.
    initial
    begin
        bad_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        converter_enable = 1'b0;
        cond = 9'h000;
        pg_pin = 1'b0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_defaults;
        t_config;
        t_flags;
        t_reassert;
        t_raw;
        t_sequence;
        stop_test;
    end

    // Watchdog well beyond the expected run of some eight hundred cycles.
    initial
    begin
        repeat (8000) @(posedge core_clk);
        bad_count++;
        stop_test;
    end
endmodule
bind pmbus_status_and_timing_config pmbus_status_monitor u_mon (.*);
`default_nettype wire
